// [rtl/scp_defs.svh]
// Constants of the serial command port: addresses, fields, reset values.
// Assumes inclusion by bare name from package and design files.
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// ---------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------
`define SCP_FRAME_BITS 16
`define SCP_FRAME_CNT_W 5
`define SCP_CNT_MAX 5'h1f
`define SCP_TXI_MAX 4'hf

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define SCP_CFG_LAST 7'h1e
`define SCP_CFG_NUM 31
`define SCP_STAT_FIRST 7'h40
`define SCP_STAT_LAST 7'h7e
`define SCP_MODE_ADDR 7'h01
`define SCP_WD_ADDR 7'h02
`define SCP_WAKE_EN_A_ADDR 7'h04
`define SCP_WAKE_EN_B_ADDR 7'h07
`define SCP_TIMER1_ADDR 7'h0c
`define SCP_TIMER2_ADDR 7'h0d

// Status registers held here, by index
`define SCP_STAT_NUM 10
`define SCP_SUP2_ADDR 7'h40
`define SCP_SUP1_ADDR 7'h41
`define SCP_THERM_ADDR 7'h42
`define SCP_DEV_ADDR 7'h43
`define SCP_BUS_ADDR 7'h44
`define SCP_WK1_ADDR 7'h46
`define SCP_WK2_ADDR 7'h47
`define SCP_WKLVL_ADDR 7'h48
`define SCP_HSOC_ADDR 7'h54
`define SCP_HSOL_ADDR 7'h55
`define SCP_SUP2_IDX 0
`define SCP_SUP1_IDX 1
`define SCP_THERM_IDX 2
`define SCP_DEV_IDX 3
`define SCP_BUS_IDX 4
`define SCP_WK1_IDX 5
`define SCP_WK2_IDX 6
`define SCP_WKLVL_IDX 7
`define SCP_HSOC_IDX 8
`define SCP_HSOL_IDX 9

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define SCP_FAIL_BIT 2
`define SCP_MODE_HI 7
`define SCP_MODE_LO 6
`define SCP_OTHER_MASK 8'h3f
`define SCP_PERIOD_HI 2
`define SCP_PERIOD_LO 0
`define SCP_ON_HI 5
`define SCP_ON_LO 3
`define SCP_CFG_RESET 8'h00
`define SCP_STAT_RESET 8'h00

`endif

// [rtl/scp_pkg.sv]
// Types of the serial command port.
// Assumes scp_defs.svh on the include path.
`default_nettype none
`include "scp_defs.svh"
package scp_pkg;
   // Received frame, LSB first on the line
   typedef struct packed {
      logic [7:0] data;
      logic access;
      logic [6:0] addr;
   } scp_frame_s;

   // Present device mode, given by the mode state machine
   typedef enum logic [2:0] {
      SCP_INIT = 3'h0,
      SCP_NORMAL = 3'h1,
      SCP_SLEEP = 3'h2,
      SCP_STOP = 3'h3,
      SCP_RESTART = 3'h4
   } scp_mode_e;

   // Mode change requested of the mode state machine
   typedef enum logic [2:0] {
      SCP_REQ_NORMAL = 3'h0,
      SCP_REQ_SLEEP = 3'h1,
      SCP_REQ_STOP = 3'h2,
      SCP_REQ_SOFT_RESET = 3'h3,
      SCP_REQ_RESTART = 3'h4
   } scp_req_e;

   typedef enum logic [1:0] {
      SCP_IDLE = 2'h0,
      SCP_ACTIVE = 2'h1,
      SCP_DECODE = 2'h3
   } scp_state_e;

   typedef logic [7:0] scp_byte_t;
endpackage : scp_pkg
`default_nettype wire

// [rtl/scp_sync.sv]
// Two-stage level synchroniser into the destination clock.
// Assumes each bit is an independent level.
`default_nettype none
module scp_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta <= '0;
         q_out <= '0;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule : scp_sync
`default_nettype wire

// [rtl/scp_port.sv]
// Serial command port: link capture on the serial clock, frame checks,
// command interpretation, status registers and summary on the core clock.
// Assumes the mode state machine reports the mode and takes requests.
`default_nettype none
`include "scp_defs.svh"
module scp_port (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic serial_clk_in,
   input wire logic select_low_pin_n_in,
   input wire logic serial_in_line_in,
   output logic serial_out_line_out,
   output logic serial_out_line_oe_n_out,
   input wire logic reset_output_pin_n_in,
   input wire scp_pkg::scp_mode_e device_mode_in,
   input wire logic [`SCP_STAT_NUM-1:0][7:0] status_event_in,
   output logic [`SCP_CFG_NUM-1:0][7:0] config_out,
   output logic mode_req_valid_out,
   output scp_pkg::scp_req_e mode_req_out,
   output logic wd_trigger_out
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_m;
   logic rst_n;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   // ---------------------------------------------------------------
   // Link side, serial clock domain
   // ---------------------------------------------------------------
   logic first;
   logic [`SCP_FRAME_CNT_W-1:0] cnt;
   logic [`SCP_FRAME_BITS-1:0] frame;
   logic start_tgl;
   logic [3:0] txi;
   logic clk_hi_fall;
   logic clk_hi_rise;

   // Arm for a new frame whenever select is high
   // Reset too, so the first frame never meets an unarmed flop
   always_ff @(negedge serial_clk_in or posedge select_low_pin_n_in
      or negedge rst_n_in) begin
      if (!rst_n_in) begin
         first <= 1'b1;
      end else if (select_low_pin_n_in) begin
         first <= 1'b1;
      end else begin
         first <= 1'b0;
      end
   end

   // Count falling edges of a frame
   always_ff @(negedge serial_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= '0;
         start_tgl <= 1'b0;
      end else if (first) begin
         cnt <= 5'h01;
         start_tgl <= ~start_tgl;
      end else if (cnt != `SCP_CNT_MAX) begin
         cnt <= cnt + 5'h01;
      end
   end

   // Bit k of the frame is the k-th bit on the input line
   always_ff @(negedge serial_clk_in) begin
      if (first) begin
         frame[0] <= serial_in_line_in;
      end else if (cnt < 5'h10) begin
         frame[cnt[3:0]] <= serial_in_line_in;
      end
   end

   // Output index advances after each rising edge
   always_ff @(posedge serial_clk_in or posedge select_low_pin_n_in
      or negedge rst_n_in) begin
      if (!rst_n_in) begin
         txi <= '0;
      end else if (select_low_pin_n_in) begin
         txi <= '0;
      end else if (txi != `SCP_TXI_MAX) begin
         txi <= txi + 4'h1;
      end
   end

   // Clock level caught at both select edges
   always_ff @(negedge select_low_pin_n_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_hi_fall <= 1'b0;
      end else begin
         clk_hi_fall <= serial_clk_in;
      end
   end

   always_ff @(posedge select_low_pin_n_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_hi_rise <= 1'b0;
      end else begin
         clk_hi_rise <= serial_clk_in;
      end
   end

   // ---------------------------------------------------------------
   // Crossings into the core clock
   // ---------------------------------------------------------------
   logic sel_s;
   logic ro_s;
   logic sel_n_s;
   logic ro_n_s;
   logic tgl_s;

   // Inverted through the stages: reset leaves both pins at idle high,
   // so no false frame or reset overlap follows reset
   scp_sync #(.W(3)) u_sync (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .d_in({~select_low_pin_n_in, ~reset_output_pin_n_in, start_tgl}),
      .q_out({sel_s, ro_s, tgl_s})
   );
   assign sel_n_s = ~sel_s;
   assign ro_n_s = ~ro_s;

   // ---------------------------------------------------------------
   // Frame sequencing
   // ---------------------------------------------------------------
   scp_pkg::scp_state_e state;
   logic tgl_seen;
   logic ro_seen;
   logic dec;

   assign dec = (state == scp_pkg::SCP_DECODE);

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= scp_pkg::SCP_IDLE;
      end else begin
         case (state)
            scp_pkg::SCP_IDLE: begin
               if (!sel_n_s) begin
                  state <= scp_pkg::SCP_ACTIVE;
               end
            end
            scp_pkg::SCP_ACTIVE: begin
               if (sel_n_s) begin
                  state <= scp_pkg::SCP_DECODE;
               end
            end
            default: begin
               state <= scp_pkg::SCP_IDLE;
            end
         endcase
      end
   end

   // Note any reset-output low during the frame
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ro_seen <= 1'b0;
      end else if (state == scp_pkg::SCP_IDLE) begin
         ro_seen <= !ro_n_s && !sel_n_s;
      end else if (state == scp_pkg::SCP_ACTIVE) begin
         ro_seen <= ro_seen || !ro_n_s;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tgl_seen <= 1'b0;
      end else if (dec) begin
         tgl_seen <= tgl_s;
      end
   end

   // ---------------------------------------------------------------
   // Command interpretation
   // ---------------------------------------------------------------
   scp_pkg::scp_frame_s f;
   logic [`SCP_STAT_NUM-1:0][7:0] stat;
   logic clocked;
   logic cnt_bad;
   logic link_bad;
   logic good;
   logic rej;
   logic cfg_we;
   logic [7:0] cfg_wdata;
   logic req_v;
   scp_pkg::scp_req_e req;
   logic wd_hit;
   logic [`SCP_STAT_NUM-1:0] clr;
   logic [1:0] tgt;
   logic [7:0] cur_mode_reg;
   logic [4:0] cfg_idx;
   logic stop;

   assign f = scp_pkg::scp_frame_s'(frame);
   assign clocked = (tgl_s != tgl_seen);
   // Count must be 0 or 16
   assign cnt_bad = clocked && (cnt != 5'h10);
   assign link_bad = cnt_bad || clk_hi_fall || clk_hi_rise || ro_seen;
   assign good = dec && clocked && !link_bad
      && (device_mode_in != scp_pkg::SCP_RESTART);
   assign cfg_idx = f.addr[4:0];
   assign cur_mode_reg = config_out[`SCP_MODE_ADDR];
   assign tgt = f.data[`SCP_MODE_HI:`SCP_MODE_LO];
   assign stop = (device_mode_in == scp_pkg::SCP_STOP);

   always_comb begin
      rej = 1'b0;
      cfg_we = 1'b0;
      cfg_wdata = f.data;
      req_v = 1'b0;
      req = scp_pkg::scp_req_e'({1'b0, tgt});
      wd_hit = 1'b0;
      if (!good) begin
         rej = 1'b0;
      end else if (frame == 16'h0000 || frame == 16'hffff) begin
         rej = 1'b1;
      end else if (f.addr <= `SCP_CFG_LAST && f.access) begin
         if (f.addr == `SCP_MODE_ADDR) begin
            req_v = 1'b1;
            cfg_we = 1'b1;
            // Stop to Sleep falls back to Restart
            if (stop && tgt == 2'h1) begin
               rej = 1'b1;
               cfg_we = 1'b0;
               req = scp_pkg::SCP_REQ_RESTART;
            end else if (device_mode_in == scp_pkg::SCP_INIT
                         && tgt[1] != tgt[0]) begin
               rej = 1'b1;
               cfg_wdata = {2'h0, f.data[5:0]};
               req = scp_pkg::SCP_REQ_NORMAL;
            // Leave Stop, keep the other bits
            end else if (stop && tgt == 2'h0) begin
               rej = ((f.data ^ cur_mode_reg) & `SCP_OTHER_MASK) != 8'h00;
               cfg_wdata = {tgt, cur_mode_reg[5:0]};
            // Stop accepts soft reset only besides Normal
            end else if (stop && tgt != 2'h3) begin
               rej = 1'b1;
               cfg_we = 1'b0;
               req_v = 1'b0;
            // Sleep without wake source: rest still executes
            end else if (tgt == 2'h1
                         && config_out[`SCP_WAKE_EN_A_ADDR] == 8'h00
                         && config_out[`SCP_WAKE_EN_B_ADDR] == 8'h00) begin
               rej = 1'b1;
               req = scp_pkg::SCP_REQ_RESTART;
            end
         // Watchdog byte must have even parity
         end else if (f.addr == `SCP_WD_ADDR) begin
            rej = ^f.data;
            cfg_we = !(^f.data);
            wd_hit = !(^f.data);
         // No other settings change in Stop
         end else if (stop) begin
            rej = 1'b1;
         // On-time must stay below the period
         end else if ((f.addr == `SCP_TIMER1_ADDR
                       || f.addr == `SCP_TIMER2_ADDR)
                      && f.data[`SCP_ON_HI:`SCP_ON_LO]
                         >= f.data[`SCP_PERIOD_HI:`SCP_PERIOD_LO]) begin
            rej = 1'b1;
         end else begin
            cfg_we = 1'b1;
         end
      end
   end

   always_comb begin
      clr = '0;
      if (good && f.access && f.addr >= `SCP_STAT_FIRST
          && frame != 16'hffff) begin
         case (f.addr)
            `SCP_SUP2_ADDR: clr[`SCP_SUP2_IDX] = 1'b1;
            `SCP_SUP1_ADDR: clr[`SCP_SUP1_IDX] = 1'b1;
            `SCP_THERM_ADDR: clr[`SCP_THERM_IDX] = 1'b1;
            `SCP_DEV_ADDR: clr[`SCP_DEV_IDX] = 1'b1;
            `SCP_BUS_ADDR: clr[`SCP_BUS_IDX] = 1'b1;
            `SCP_WK1_ADDR: clr[`SCP_WK1_IDX] = 1'b1;
            `SCP_WK2_ADDR: clr[`SCP_WK2_IDX] = 1'b1;
            `SCP_HSOC_ADDR: clr[`SCP_HSOC_IDX] = 1'b1;
            `SCP_HSOL_ADDR: clr[`SCP_HSOL_IDX] = 1'b1;
            default: clr = '0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic err_q;
   logic [`SCP_CFG_NUM-1:0][7:0] sh_cfg;
   logic [`SCP_STAT_NUM-1:0][7:0] sh_stat;
   logic [7:0] sum;
   logic [7:0] sh_sum;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         config_out <= '{default: `SCP_CFG_RESET};
      end else if (cfg_we) begin
         config_out[cfg_idx] <= cfg_wdata;
      end
   end

   // Events set, only a clear command clears; set wins; wake level register follows its input
   genvar gi;
   generate
      for (gi = 0; gi < `SCP_STAT_NUM; gi++) begin : g_stat
         always_ff @(posedge core_clk_in or negedge rst_n) begin
            if (!rst_n) begin
               stat[gi] <= `SCP_STAT_RESET;
            end else if (gi == `SCP_WKLVL_IDX) begin
               stat[gi] <= status_event_in[gi];
            end else if (gi == `SCP_DEV_IDX) begin
               stat[gi] <= (stat[gi] & ~{8{clr[gi]}}) | status_event_in[gi]
                  | (8'(rej) << `SCP_FAIL_BIT);
            end else begin
               stat[gi] <= (stat[gi] & ~{8{clr[gi]}}) | status_event_in[gi];
            end
         end
      end
   endgenerate

   // Error shown in the frame after a faulty one
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         err_q <= 1'b0;
      end else if (dec) begin
         err_q <= link_bad;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         mode_req_valid_out <= 1'b0;
         mode_req_out <= scp_pkg::SCP_REQ_NORMAL;
         wd_trigger_out <= 1'b0;
      end else begin
         mode_req_valid_out <= req_v;
         mode_req_out <= req;
         wd_trigger_out <= wd_hit;
      end
   end

   // Summary, wake level register left out
   assign sum = {|stat[`SCP_HSOL_IDX], |stat[`SCP_HSOC_IDX],
      |stat[`SCP_SUP2_IDX], |stat[`SCP_WK1_IDX] | |stat[`SCP_WK2_IDX],
      |stat[`SCP_BUS_IDX], |stat[`SCP_DEV_IDX], |stat[`SCP_THERM_IDX],
      |stat[`SCP_SUP1_IDX]};

   // Frozen copy for the link; only moves between frames
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sh_cfg <= '{default: `SCP_CFG_RESET};
         sh_stat <= '{default: `SCP_STAT_RESET};
         sh_sum <= 8'h00;
      end else if (state == scp_pkg::SCP_IDLE && sel_n_s) begin
         sh_cfg <= config_out;
         sh_stat <= stat;
         sh_sum <= sum;
      end
   end

   // ---------------------------------------------------------------
   // Response word and output pin
   // ---------------------------------------------------------------
   logic [7:0] rd_byte;
   logic [15:0] resp;

   // Byte of the addressed register, same frame
   always_comb begin
      rd_byte = 8'h00;
      if (frame[6:0] <= `SCP_CFG_LAST) begin
         rd_byte = sh_cfg[frame[4:0]];
      end else begin
         case (frame[6:0])
            `SCP_SUP2_ADDR: rd_byte = sh_stat[`SCP_SUP2_IDX];
            `SCP_SUP1_ADDR: rd_byte = sh_stat[`SCP_SUP1_IDX];
            `SCP_THERM_ADDR: rd_byte = sh_stat[`SCP_THERM_IDX];
            `SCP_DEV_ADDR: rd_byte = sh_stat[`SCP_DEV_IDX];
            `SCP_BUS_ADDR: rd_byte = sh_stat[`SCP_BUS_IDX];
            `SCP_WK1_ADDR: rd_byte = sh_stat[`SCP_WK1_IDX];
            `SCP_WK2_ADDR: rd_byte = sh_stat[`SCP_WK2_IDX];
            `SCP_WKLVL_ADDR: rd_byte = sh_stat[`SCP_WKLVL_IDX];
            `SCP_HSOC_ADDR: rd_byte = sh_stat[`SCP_HSOC_IDX];
            `SCP_HSOL_ADDR: rd_byte = sh_stat[`SCP_HSOL_IDX];
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // Data high byte, summary low; error forces bit 0
   assign resp = {rd_byte, sh_sum[7:1], sh_sum[0] | err_q};
   // Output held high while reset output is low
   assign serial_out_line_out = !ro_n_s || resp[txi];
   // Driven only while selected, no pass-through
   assign serial_out_line_oe_n_out = select_low_pin_n_in;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n);

   a_fail_sticky: assert property (
      $fell(stat[`SCP_DEV_IDX][`SCP_FAIL_BIT]) |-> $past(clr[`SCP_DEV_IDX]))
      else $error("reject flag cleared without clear command");
   a_restart_drop: assert property (
      dec && device_mode_in == scp_pkg::SCP_RESTART |-> !cfg_we && !req_v)
      else $error("frame acted on in restart mode");
   a_count_err: assert property (
      dec && cnt_bad |-> !cfg_we ##1 err_q [*2])
      else $error("bad clock count not flagged");
   a_stuck_rej: assert property (
      good && frame == 16'hffff |-> !cfg_we ##1
      stat[`SCP_DEV_IDX][`SCP_FAIL_BIT])
      else $error("stuck frame not rejected");
   a_wd_parity: assert property (
      good && f.access && f.addr == `SCP_WD_ADDR && ^f.data
      && frame != 16'hffff |=> !wd_trigger_out
      && stat[`SCP_DEV_IDX][`SCP_FAIL_BIT])
      else $error("odd parity watchdog accepted");
   a_stop_sleep: assert property (
      good && stop && f.access && f.addr == `SCP_MODE_ADDR && tgt == 2'h1
      |=> mode_req_valid_out && mode_req_out == scp_pkg::SCP_REQ_RESTART)
      else $error("stop to sleep did not force restart");
   a_stop_hold: assert property (
      $changed(config_out) && $past(stop) |->
      $past(f.addr) == `SCP_MODE_ADDR || $past(f.addr) == `SCP_WD_ADDR)
      else $error("setting changed in stop mode");
   a_sum_clear: assert property (
      $fell(|stat[`SCP_SUP1_IDX]) |-> ##1 sel_n_s && state ==
      scp_pkg::SCP_IDLE |-> ##1 !sh_sum[0])
      else $error("summary bit did not drop");
   a_timer_rej: assert property (
      good && f.access && !stop && f.addr == `SCP_TIMER1_ADDR
      && f.data[5:3] >= f.data[2:0] && frame != 16'hffff
      |=> $stable(config_out[`SCP_TIMER1_ADDR]))
      else $error("bad timer setting written");
endmodule : scp_port
`default_nettype wire

// [tb/scp_master.sv]
// Serial master model facing the command port, LSB first.
// Assumes a 32 ns bit period and a serial clock idle low.
`default_nettype none
module scp_master (
   output logic sck_out,
   output logic sel_n_out,
   output logic sdi_out,
   input wire logic sdo_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck_out = 1'b0;
      sel_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, input int n,
         output logic [15:0] rx);
      rx = 16'h0000;
      sel_n_out = 1'b0;
      #16;
      for (int k = 0; k < n; k++) begin
         rx[k] = sdo_in;
         sdi_out = tx[k];
         #8 sck_out = 1'b1;
         #16 sck_out = 1'b0;
         #8;
      end
      if (n == 0) rx[0] = sdo_in;
      // Idle line toggled so a stale bit never reads as data
      sdi_out = ~sdi_out;
      #8 sel_n_out = 1'b1;
      #80;
   endtask : xfer
endmodule : scp_master
`default_nettype wire

// [tb/scp_port_test.sv]
// Self-checking bench of the serial command port.
// Assumes scp_master.sv and the design under rtl/.
`default_nettype none
`include "scp_defs.svh"
module scp_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, sck, sel_n, serial_in_line, serial_out_line, oe_n, ro_n, vld, wdt;
   scp_pkg::scp_mode_e mode;
   scp_pkg::scp_req_e req, last_req;
   logic [`SCP_STAT_NUM-1:0][7:0] ev;
   logic [`SCP_CFG_NUM-1:0][7:0] cfg;
   logic [15:0] rx;
   int n_mismatch = 0, samples_checked = 0, cyc = 0, wd_cnt = 0;
   int si [9] = '{0, 1, 2, 3, 4, 5, 6, 8, 9};
   logic [6:0] sa [9] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46,
      7'h47, 7'h54, 7'h55};
   logic [7:0] sb [9] = '{8'h20, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
      8'h10, 8'h40, 8'h80};
   scp_port scp_port_inst (.core_clk_in(clk), .rst_n_in(rst_n),
      .serial_clk_in(sck), .select_low_pin_n_in(sel_n),
      .serial_in_line_in(serial_in_line), .serial_out_line_out(serial_out_line),
      .serial_out_line_oe_n_out(oe_n), .reset_output_pin_n_in(ro_n),
      .device_mode_in(mode), .status_event_in(ev), .config_out(cfg),
      .mode_req_valid_out(vld), .mode_req_out(req),
      .wd_trigger_out(wdt));
   scp_master scp_master_inst (.sck_out(sck), .sel_n_out(sel_n),
      .sdi_out(serial_in_line), .sdo_in(serial_out_line));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (vld) last_req <= req;
      if (wdt) wd_cnt <= wd_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic go(input logic [15:0] tx);
      scp_master_inst.xfer(tx, 16, rx);
   endtask : go
   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_write;
      go(16'ha585);
      chk(rx, 16'h0000);
      chk({8'h00, cfg[5]}, 16'h00a5);
      go(16'h0005);
      chk(rx, 16'ha500);
      chk({15'h0000, oe_n}, 16'h0001);
   endtask : t_write
   task automatic t_status;
      for (int i = 0; i < 9; i++) begin
         ev[si[i]] = 8'h01;
         tick(2);
         ev[si[i]] = 8'h00;
         tick(4);
         go({8'h00, 1'b0, sa[i]});
         chk(rx, {8'h01, sb[i]});
         go({8'h00, 1'b1, sa[i]});
         chk(rx, {8'h01, sb[i]});
         go({8'h00, 1'b0, sa[i]});
         chk(rx, 16'h0000);
      end
   endtask : t_status
   task automatic t_link_err;
      scp_master_inst.xfer(16'h0005, 8, rx);
      scp_master_inst.xfer(16'h0000, 0, rx);
      chk({15'h0000, rx[0]}, 16'h0001);
      scp_master_inst.xfer(16'h0000, 0, rx);
      chk({15'h0000, rx[0]}, 16'h0000);
   endtask : t_link_err
   task automatic rejected(input logic [15:0] tx);
      go(tx);
      go(16'h0043);
      chk(rx, 16'h0404);
      go(16'h00c3);
   endtask : rejected
   task automatic t_reject;
      rejected(16'hffff);
      rejected(16'h0000);
      rejected(16'h1b8c);
      chk({8'h00, cfg[12]}, 16'h0000);
      rejected(16'h0182);
      go(16'h0382);
      chk(16'(wd_cnt), 16'h0001);
      mode = scp_pkg::SCP_STOP;
      rejected(16'h3c85);
      chk({8'h00, cfg[5]}, 16'h00a5);
      rejected(16'h4081);
      chk(16'(last_req), 16'(scp_pkg::SCP_REQ_RESTART));
      mode = scp_pkg::SCP_INIT;
      rejected(16'h8081);
      chk(16'(last_req), 16'(scp_pkg::SCP_REQ_NORMAL));
      mode = scp_pkg::SCP_RESTART;
      go(16'h3c85);
      mode = scp_pkg::SCP_NORMAL;
      chk({8'h00, cfg[5]}, 16'h00a5);
   endtask : t_reject
   task automatic t_mode;
      rejected(16'h4681);
      chk(16'(last_req), 16'(scp_pkg::SCP_REQ_RESTART));
      chk({8'h00, cfg[1]}, 16'h0046);
      mode = scp_pkg::SCP_STOP;
      rejected(16'h0581);
      chk({8'h00, cfg[1]}, 16'h0006);
      chk(16'(last_req), 16'(scp_pkg::SCP_REQ_NORMAL));
      go(16'hc081);
      chk(16'(last_req), 16'(scp_pkg::SCP_REQ_SOFT_RESET));
      go(16'h0043);
      chk(rx, 16'h0000);
      mode = scp_pkg::SCP_NORMAL;
   endtask : t_mode
   task automatic t_reset_pin;
      ro_n = 1'b0;
      tick(4);
      go(16'h0005);
      chk(rx, 16'hffff);
      ro_n = 1'b1;
      tick(4);
      go(16'h0005);
      chk(rx, 16'ha501);
   endtask : t_reset_pin
   initial begin
      rst_n = 1'b0;
      ro_n = 1'b1;
      mode = scp_pkg::SCP_NORMAL;
      ev = '0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      tick(6);
      t_write();
      t_status();
      t_link_err();
      t_reject();
      t_mode();
      t_reset_pin();
      wrap_up();
   end
endmodule : scp_port_test
`default_nettype wire
